// [pfcc_control.sv]
// PFC control register bank with run sequencer, gate polarity and OCP.
// Assumes an APB master on core_clk; fault and OCP inputs are raw pins;
// PWM requests and period tick come from the modulator on core_clk.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - sys config [3:0]: loop every N periods
// - sys config bit5: latch-off or cycle-by-cycle OCP; totem-pole always latches off
// - hw config bit10 selects AC voltage sensing
// - read-only state: 0,1,2,4,5 codes
// - offset measurement state precedes running
// - state codes 0 to 5, zero after reset
// - command 0 stops, 1 starts converter
module pfcc_control #(
  parameter int POWER_ON_CYCLES = pfcc_pkg::POWER_ON_CYCLES,
  parameter int OFFSET_CYCLES   = pfcc_pkg::OFFSET_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pwm_tick,
  input  wire logic        pwm_low_req,
  input  wire logic        pwm_high_req,
  input  wire logic        fault_pin,
  input  wire logic        ocp_pin,
  output logic             gate_low,
  output logic             gate_high,
  output logic             loop_exec,
  output logic             totem_pole,
  output logic             current_mode,
  output logic             vac_single_ended,
  output logic [1:0]       current_gain,
  output logic             isense_invert,
  output logic [1:0]       ocp_hysteresis,
  output logic             offset_meas_active,
  output logic             converter_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0] hardware_config_word;   // Board setup
  logic [15:0] system_config_word;     // Control setup
  logic [15:0] run_command;            // Start or stop request
  logic [15:0] sequence_state;         // Code of current state
  pfcc_pkg::pfcc_state_type state;
  pfcc_pkg::pfcc_state_type next_state;
  logic [15:0] phase_cnt;              // Cycles spent in timed state
  logic [1:0]  fault_sync;             // Fault pin synchroniser
  logic [1:0]  ocp_sync;               // OCP pin synchroniser
  logic        ocp_kill;               // Pulse cut for this period
  logic        setup_ph;               // APB setup cycle
  logic        wr_en;                  // APB write completes
  logic        addr_ok;                // Address maps to a register
  logic        ocp_cbc;                // Cycle-by-cycle style active
  logic        fault_trip;             // Any latching fault event

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup_ph = psel && !penable;
  assign pready   = psel && penable;   // Zero wait states
  assign wr_en    = psel && penable && pwrite && !pslverr;
  assign addr_ok  = (paddr == pfcc_pkg::ADDR_HW_CFG) || (paddr == pfcc_pkg::ADDR_SYS_CFG)
                 || (paddr == pfcc_pkg::ADDR_SEQ) || (paddr == pfcc_pkg::ADDR_CMD);

  // Read data and error captured in setup, held through access
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      // Unmapped or writes to the state variable are refused
      pslverr <= !addr_ok || (pwrite && paddr == pfcc_pkg::ADDR_SEQ);
      unique case (paddr)
        pfcc_pkg::ADDR_HW_CFG:  prdata <= {16'h0000, hardware_config_word};
        pfcc_pkg::ADDR_SYS_CFG: prdata <= {16'h0000, system_config_word};
        pfcc_pkg::ADDR_SEQ:     prdata <= {16'h0000, sequence_state};
        pfcc_pkg::ADDR_CMD:     prdata <= {16'h0000, run_command};
        default:                prdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; reserved configuration bits are not stored and read as zero, the command word is stored whole
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hardware_config_word <= pfcc_pkg::HW_CFG_RST;
      system_config_word   <= pfcc_pkg::SYS_CFG_RST;
      run_command          <= pfcc_pkg::CMD_RST;   // Stopped until started
    end else if (wr_en) begin
      if (paddr == pfcc_pkg::ADDR_HW_CFG)
        hardware_config_word <= pwdata[15:0] & pfcc_pkg::HW_CFG_MASK;
      if (paddr == pfcc_pkg::ADDR_SYS_CFG)
        system_config_word <= pwdata[15:0] & pfcc_pkg::SYS_CFG_MASK;
      if (paddr == pfcc_pkg::ADDR_CMD)
        run_command <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Static configuration outputs
  assign totem_pole       = hardware_config_word[pfcc_pkg::HW_TOPO_BIT];
  assign current_mode     = system_config_word[pfcc_pkg::SYS_MODE_BIT];
  assign vac_single_ended = hardware_config_word[pfcc_pkg::HW_VSENSE_BIT];
  assign current_gain     = hardware_config_word[pfcc_pkg::HW_GAIN_LSB +: 2];
  assign isense_invert    = hardware_config_word[pfcc_pkg::HW_ISPOL_BIT];
  assign ocp_hysteresis   = system_config_word[pfcc_pkg::SYS_HYST_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_sync <= 2'b00;
      ocp_sync   <= 2'b00;
    end else begin
      fault_sync <= {fault_sync[0], fault_pin};
      ocp_sync   <= {ocp_sync[0], ocp_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent style; totem-pole always latches off
  assign ocp_cbc    = !totem_pole && system_config_word[pfcc_pkg::SYS_OCP_BIT];
  assign fault_trip = fault_sync[1] || (ocp_sync[1] && !ocp_cbc);

  // Cycle-by-cycle cut holds to the next period; a trip wins over the tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      ocp_kill <= 1'b0;
    else if (ocp_sync[1] && ocp_cbc && state == pfcc_pkg::ST_RUN)
      ocp_kill <= 1'b1;
    else if (pwm_tick || state != pfcc_pkg::ST_RUN)
      ocp_kill <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      pfcc_pkg::ST_POWER_ON:
        if (phase_cnt == 16'(POWER_ON_CYCLES - 1)) next_state = pfcc_pkg::ST_STOP;
      pfcc_pkg::ST_STOP:
        if (run_command == pfcc_pkg::CMD_START) next_state = pfcc_pkg::ST_OFFSET;
      pfcc_pkg::ST_OFFSET: begin
        // Faults outrank commands
        if (fault_trip) next_state = pfcc_pkg::ST_FAULT;
        else if (run_command == pfcc_pkg::CMD_STOP) next_state = pfcc_pkg::ST_STOP;
        else if (phase_cnt == 16'(OFFSET_CYCLES - 1)) next_state = pfcc_pkg::ST_RUN;
      end
      pfcc_pkg::ST_RUN: begin
        if (fault_trip) next_state = pfcc_pkg::ST_FAULT;
        else if (run_command == pfcc_pkg::CMD_STOP) next_state = pfcc_pkg::ST_STOP;
      end
      pfcc_pkg::ST_FAULT:
        // Fault is left only by a stop command
        if (run_command == pfcc_pkg::CMD_STOP) next_state = pfcc_pkg::ST_STOP;
      default: next_state = pfcc_pkg::ST_POWER_ON;
    endcase
  end

  // Sequencer state and phase counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= pfcc_pkg::ST_POWER_ON;
      phase_cnt <= '0;
    end else begin
      state     <= next_state;
      phase_cnt <= (next_state != state) ? 16'h0000 : phase_cnt + 16'h0001;
    end
  end

  // Code shown to software; only legal codes are produced
  always_comb begin
    unique case (state)
      pfcc_pkg::ST_POWER_ON: sequence_state = pfcc_pkg::CODE_POWER_ON;
      pfcc_pkg::ST_STOP:     sequence_state = pfcc_pkg::CODE_STOP;
      pfcc_pkg::ST_OFFSET:   sequence_state = pfcc_pkg::CODE_OFFSET;
      pfcc_pkg::ST_RUN:      sequence_state = pfcc_pkg::CODE_RUN;
      pfcc_pkg::ST_FAULT:    sequence_state = pfcc_pkg::CODE_FAULT;
      default:               sequence_state = pfcc_pkg::CODE_POWER_ON;
    endcase
  end

  assign converter_running  = (state == pfcc_pkg::ST_RUN);
  assign offset_meas_active = (state == pfcc_pkg::ST_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive: inactive level outside running, polarity per bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_low  <= 1'b0;
      gate_high <= 1'b0;
    end else begin
      gate_low  <= (converter_running && pwm_low_req && !ocp_kill)
                 ^ hardware_config_word[pfcc_pkg::HW_LPOL_BIT];
      gate_high <= (converter_running && pwm_high_req && !ocp_kill)
                 ^ hardware_config_word[pfcc_pkg::HW_HPOL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current-loop rate, only while running
  pfcc_loop_divider #(
    .RATE_W (4)
  ) u_loop_div (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .enable   (converter_running),
    .tick     (pwm_tick),
    .rate     (system_config_word[pfcc_pkg::SYS_RATE_LSB +: 4]),
    .fire     (loop_exec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  state_code_range_a: assert property (
    sequence_state inside {16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0005})
    else $error("state code outside legal set");
  offset_before_run_a: assert property (
    $rose(converter_running) |-> $past(offset_meas_active))
    else $error("running entered without offset measurement");
  start_cmd_a: assert property (
    state == pfcc_pkg::ST_STOP && run_command == pfcc_pkg::CMD_START
    |=> sequence_state == pfcc_pkg::CODE_OFFSET)
    else $error("start command did not begin offset measurement");
  stop_cmd_a: assert property (
    converter_running && !fault_trip && run_command == pfcc_pkg::CMD_STOP
    |=> sequence_state == pfcc_pkg::CODE_STOP)
    else $error("stop command did not stop converter");
  ocp_latch_a: assert property (
    converter_running && ocp_sync[1] && !system_config_word[pfcc_pkg::SYS_OCP_BIT]
    |=> sequence_state == pfcc_pkg::CODE_FAULT)
    else $error("latch-off overcurrent did not fault");
  ocp_cycle_a: assert property (
    converter_running && ocp_sync[1] && system_config_word[pfcc_pkg::SYS_OCP_BIT] && !totem_pole
    |=> ocp_kill ##1 gate_low == hardware_config_word[pfcc_pkg::HW_LPOL_BIT])
    else $error("cycle-by-cycle limit did not cut pulse");
  vsense_write_a: assert property (
    wr_en && paddr == pfcc_pkg::ADDR_HW_CFG
    |=> vac_single_ended == $past(pwdata[pfcc_pkg::HW_VSENSE_BIT]))
    else $error("voltage sensing select not updated");
  gate_polarity_a: assert property (
    !converter_running |=> gate_low == $past(hardware_config_word[pfcc_pkg::HW_LPOL_BIT])
                        && gate_high == $past(hardware_config_word[pfcc_pkg::HW_HPOL_BIT]))
    else $error("idle gate level wrong for polarity");
  loop_every_a: assert property (
    converter_running && pwm_tick && system_config_word[pfcc_pkg::SYS_RATE_LSB +: 4] == 4'h1
    ##1 converter_running |-> loop_exec)
    else $error("loop not run every period at rate one");
  state_read_a: assert property (
    setup_ph && paddr == pfcc_pkg::ADDR_SEQ |=> prdata[15:0] == $past(sequence_state))
    else $error("state read returned wrong code");

  run_reached_c:   cover property (converter_running);
  fault_reached_c: cover property (sequence_state == pfcc_pkg::CODE_FAULT);
  cbc_cut_c:       cover property (ocp_kill && converter_running);
  loop_fired_c:    cover property (loop_exec);

endmodule
`default_nettype wire

// [pfcc_pkg.sv]
// Shared constants for the PFC control register bank: register indices,
// byte addresses, field positions, reset values, state codes and timing.
// Assumes a 100 ns core clock and a 12-bit APB byte address.
package pfcc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_HW_CFG   = 8'h01;
  localparam logic [7:0]  IDX_SYS_CFG  = 8'h02;
  localparam logic [7:0]  IDX_SEQ      = 8'h51;
  localparam logic [7:0]  IDX_CMD      = 8'h52;
  localparam logic [11:0] ADDR_HW_CFG  = {2'b00, IDX_HW_CFG, 2'b00};
  localparam logic [11:0] ADDR_SYS_CFG = {2'b00, IDX_SYS_CFG, 2'b00};
  localparam logic [11:0] ADDR_SEQ     = {2'b00, IDX_SEQ, 2'b00};
  localparam logic [11:0] ADDR_CMD     = {2'b00, IDX_CMD, 2'b00};

  // Hardware configuration word fields
  localparam int HW_TOPO_BIT   = 0;
  localparam int HW_LPOL_BIT   = 5;
  localparam int HW_HPOL_BIT   = 6;
  localparam int HW_GAIN_LSB   = 7;
  localparam int HW_ISPOL_BIT  = 9;
  localparam int HW_VSENSE_BIT = 10;
  localparam logic [15:0] HW_CFG_MASK = 16'h07E1;

  // System configuration word fields
  localparam int SYS_RATE_LSB = 0;
  localparam int SYS_MODE_BIT = 4;
  localparam int SYS_OCP_BIT  = 5;
  localparam int SYS_HYST_LSB = 6;
  localparam logic [15:0] SYS_CFG_MASK = 16'h00FF;

  // Reset values
  localparam logic [15:0] HW_CFG_RST  = 16'h0000;
  localparam logic [15:0] SYS_CFG_RST = 16'h0000;
  localparam logic [15:0] CMD_RST     = 16'h0000;

  // Run command values
  localparam logic [15:0] CMD_STOP  = 16'h0000;
  localparam logic [15:0] CMD_START = 16'h0001;

  // Sequencer state codes as software reads them
  localparam logic [15:0] CODE_POWER_ON = 16'h0000;
  localparam logic [15:0] CODE_STOP     = 16'h0001;
  localparam logic [15:0] CODE_OFFSET   = 16'h0002;
  localparam logic [15:0] CODE_RUN      = 16'h0004;
  localparam logic [15:0] CODE_FAULT    = 16'h0005;

  // Timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int POWER_ON_NS     = 1600;
  localparam int OFFSET_MEAS_NS  = 102400;
  localparam int POWER_ON_CYCLES =
    (POWER_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFFSET_CYCLES   =
    (OFFSET_MEAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_POWER_ON,
    ST_STOP,
    ST_OFFSET,
    ST_RUN,
    ST_FAULT
  } pfcc_state_type;

endpackage

// [pfcc_loop_divider.sv]
// Current-loop rate divider: fires once every N PWM period ticks.
// Assumes tick is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pfcc_loop_divider #(
  parameter int RATE_W = 4
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              enable,
  input  wire logic              tick,
  input  wire logic [RATE_W-1:0] rate,
  output logic                   fire
);

  logic [RATE_W-1:0] count;  // Ticks seen since last firing

  // Count ticks; rate zero never fires, as no period count is meaningful
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      fire  <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      fire  <= 1'b0;
    end else if (tick && rate != '0) begin
      if (count + RATE_W'(1) >= rate) begin
        count <= '0;
        fire  <= 1'b1;
      end else begin
        count <= count + RATE_W'(1);
        fire  <= 1'b0;
      end
    end else begin
      fire <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [pfcc_control_test.sv]
// Self-checking bench for the PFC control register bank.
// Assumes pfcc_pkg is compiled first; the APB master and all pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module pfcc_control_test;
  logic        core_clk;     // 10 MHz core clock
  logic        arst_n;       // Async reset, active low
  logic        psel;         // APB select
  logic        penable;      // APB enable
  logic        pwrite;       // APB direction
  logic [11:0] paddr;        // APB byte address
  logic [31:0] pwdata;       // APB write data
  logic [31:0] prdata;       // APB read data
  logic        pready;       // APB ready
  logic        pslverr;      // APB error
  logic        pwm_tick;     // PWM period start pulse
  logic        pwm_low_req;  // Low-side request
  logic        pwm_high_req; // High-side request
  logic        fault_pin;    // External fault
  logic        ocp_pin;      // Overcurrent comparator
  logic        gate_low;
  logic        gate_high;
  logic        loop_exec;
  logic        totem_pole;
  logic        current_mode;
  logic        vac_single_ended;
  logic [1:0]  current_gain;
  logic        isense_invert;
  logic [1:0]  ocp_hysteresis;
  logic        offset_meas_active;
  logic        converter_running;
  int          mismatches;   // Failed comparisons
  int          checks_done;  // All comparisons
  int          exec_count = 0; // Loop pulses seen
  int          exec_base;    // Count at scenario start
  logic [31:0] rd;           // Last read data
  logic        err;          // Last error flag

  // Short sequencer counts keep the run brief
  pfcc_control #(.POWER_ON_CYCLES(4), .OFFSET_CYCLES(8)) u_pfcc_control (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_tick(pwm_tick),
    .pwm_low_req(pwm_low_req), .pwm_high_req(pwm_high_req),
    .fault_pin(fault_pin), .ocp_pin(ocp_pin), .gate_low(gate_low),
    .gate_high(gate_high), .loop_exec(loop_exec), .totem_pole(totem_pole),
    .current_mode(current_mode), .vac_single_ended(vac_single_ended),
    .current_gain(current_gain), .isense_invert(isense_invert),
    .ocp_hysteresis(ocp_hysteresis), .offset_meas_active(offset_meas_active),
    .converter_running(converter_running));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and loop pulse counter
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (loop_exec === 1'b1) exec_count <= exec_count + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        complete_run();
      end
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls the state word until it shows the code, bounded
  task automatic wait_code(input logic [15:0] code);
    int n;
    n = 0;
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    while (rd[15:0] !== code) begin
      n++;
      if (n > 40) begin
        mismatches++;
        complete_run();
      end
      apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    end
  endtask

  task automatic ticks(input int cnt);
    repeat (cnt) begin
      @(posedge core_clk) pwm_tick <= 1'b1;
      @(posedge core_clk) pwm_tick <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("state at reset", 32'h0000_0000, rd);
    apb(1'b0, pfcc_pkg::ADDR_CMD, 32'h0000_0000);
    chk("command at reset", 32'h0000_0000, rd);
    apb(1'b0, pfcc_pkg::ADDR_HW_CFG, 32'h0000_0000);
    chk("hw at reset", 32'h0000_0000, rd);
    wait_code(pfcc_pkg::CODE_STOP);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    apb(1'b1, pfcc_pkg::ADDR_HW_CFG, 32'hFFFF_FFFF);
    apb(1'b0, pfcc_pkg::ADDR_HW_CFG, 32'h0000_0000);
    chk("hw reserved bits", 32'h0000_07E1, rd);
    chk("vac sensing", 32'h1, {31'h0, vac_single_ended});
    chk("topology", 32'h1, {31'h0, totem_pole});
    chk("current gain", 32'h3, {30'h0, current_gain});
    chk("sensing invert", 32'h1, {31'h0, isense_invert});
    apb(1'b1, pfcc_pkg::ADDR_SYS_CFG, 32'h0000_FFFF);
    apb(1'b0, pfcc_pkg::ADDR_SYS_CFG, 32'h0000_0000);
    chk("sys reserved bits", 32'h0000_00FF, rd);
    chk("control mode", 32'h1, {31'h0, current_mode});
    chk("ocp hysteresis", 32'h3, {30'h0, ocp_hysteresis});
    apb(1'b1, pfcc_pkg::ADDR_SEQ, 32'h0000_0004);
    chk("state write error", 32'h1, {31'h0, err});
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("state unchanged", 32'h0000_0001, rd);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, pfcc_pkg::ADDR_HW_CFG, 32'h0000_0000);
    // Let the written word settle before looking at the pin
    @(posedge core_clk);
    chk("vac differential", 32'h0, {31'h0, vac_single_ended});
    $display("t_regs done");
  endtask

  task automatic t_run();
    apb(1'b1, pfcc_pkg::ADDR_SYS_CFG, 32'h0000_0003); // Rate 3, latch-off
    apb(1'b1, pfcc_pkg::ADDR_CMD, pfcc_pkg::CMD_START);
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("offset state", 32'h0000_0002, rd);
    chk("offset flag", 32'h1, {31'h0, offset_meas_active});
    wait_code(pfcc_pkg::CODE_RUN);
    chk("running flag", 32'h1, {31'h0, converter_running});
    // Low side active low, high side active high
    apb(1'b1, pfcc_pkg::ADDR_HW_CFG, 32'h0000_0020);
    @(posedge core_clk) pwm_low_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("gate low active low", 32'h0, {31'h0, gate_low});
    chk("gate high idle", 32'h0, {31'h0, gate_high});
    @(posedge core_clk) pwm_high_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("gate high active", 32'h1, {31'h0, gate_high});
    exec_base = exec_count;
    ticks(6);
    repeat (3) @(posedge core_clk);
    chk("loop every 3", 32'h0000_0002, 32'(exec_count - exec_base));
    // Rate one runs the loop on every period
    apb(1'b1, pfcc_pkg::ADDR_SYS_CFG, 32'h0000_0001);
    exec_base = exec_count;
    ticks(2);
    repeat (3) @(posedge core_clk);
    chk("loop every 1", 32'h0000_0002, 32'(exec_count - exec_base));
    apb(1'b1, pfcc_pkg::ADDR_CMD, pfcc_pkg::CMD_STOP);
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("stopped", 32'h0000_0001, rd);
    chk("gate low off", 32'h1, {31'h0, gate_low});
    $display("t_run done");
  endtask

  task automatic t_ocp();
    apb(1'b1, pfcc_pkg::ADDR_HW_CFG, 32'h0000_0000);
    apb(1'b1, pfcc_pkg::ADDR_CMD, pfcc_pkg::CMD_START);
    wait_code(pfcc_pkg::CODE_RUN);
    @(posedge core_clk) ocp_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    ocp_pin <= 1'b0;
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("latch-off fault", 32'h0000_0005, rd);
    apb(1'b1, pfcc_pkg::ADDR_CMD, pfcc_pkg::CMD_STOP);
    wait_code(pfcc_pkg::CODE_STOP);
    // Cycle-by-cycle style keeps running and blanks until next period
    apb(1'b1, pfcc_pkg::ADDR_SYS_CFG, 32'h0000_0023);
    apb(1'b1, pfcc_pkg::ADDR_CMD, pfcc_pkg::CMD_START);
    wait_code(pfcc_pkg::CODE_RUN);
    @(posedge core_clk) ocp_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    ocp_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("gate blanked", 32'h0, {31'h0, gate_low});
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("still running", 32'h0000_0004, rd);
    ticks(1);
    repeat (3) @(posedge core_clk);
    chk("gate restored", 32'h1, {31'h0, gate_low});
    // Fault pin trips the sequencer whatever the OCP style
    @(posedge core_clk) fault_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    fault_pin <= 1'b0;
    apb(1'b0, pfcc_pkg::ADDR_SEQ, 32'h0000_0000);
    chk("fault pin", 32'h0000_0005, rd);
    $display("t_ocp done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pwm_tick = 1'b0;
    pwm_low_req = 1'b0;
    pwm_high_req = 1'b0;
    fault_pin = 1'b0;
    ocp_pin = 1'b0;
    mismatches = 0;
    checks_done = 0;
    rd = 32'h0;
    err = 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_run();
    t_ocp();
    complete_run();
  end
endmodule
`default_nettype wire
